// ### dtt_debug_regs.sv
// debug comparator, trace fifo and control register block of an 8-bit mcu
// assumes one bus clock, synchronous reset from the mcu reset, and that
// trigger mode and begin/end selection arrive as levels from outside
// Contract
// - force reset: host-only writes, reads zero
// - host writes bit0 one: full reset
// - comparators reset zero, written only unarmed
// - nine debug bytes in normal map; the cpu map here has seven (indices 0 to 6)
// - fifo high read-only; zero in event-only
// - high read never advances fifo
// - low read-only; every unarmed read shifts fifo
// - event-only stores bytes in low half
// - armed low reads do not advance
// - unarmed low read stores opcode address last
// - eight deep: ninth read sees first
// - control register always readable and writable
// - bit7 enables; cannot set while secured
// - bit6 arms; run end clears it
// - bit5 selects force or tag break
// - bit4 breaks: trigger or fifo full
// - bits2/3 qualify comparator a direction
// - bits0/1 qualify comparator b direction
// - run ends at full or trigger
// - count clears at arm, never decrements
`include "dtt_regs.svh"

module dtt_debug_regs #(
    parameter int DEPTH = 8  // trace fifo words
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // cpu register port
    input  wire dtt_pkg::dtt_reg_req_s cpu_req_i,
    output logic [7:0]                cpu_rdata_o,
    // background debug host write port
    input  wire dtt_pkg::dtt_reg_req_s host_req_i,
    output logic                      force_reset_o,
    // mcu state and bus observation
    input  wire logic                 secure_i,
    input  wire dtt_pkg::dtt_bus_s    bus_i,
    input  wire logic                 cof_valid_i,
    input  wire logic [15:0]          cof_addr_i,
    input  wire logic [15:0]          opcode_addr_i,
    // trigger setup held elsewhere
    input  wire logic                 begin_trace_i,
    input  wire logic                 event_only_i,
    input  wire logic                 trig_use_b_i,
    // status and break outputs
    output logic                      armed_o,
    output logic [3:0]                count_o,
    output logic                      match_a_o,
    output logic                      match_b_o,
    output logic                      brk_req_o,
    output logic                      brk_tag_o
);

    // the shift chain and the 4-bit count are built for exactly eight words
    if (DEPTH != 8) begin : g_depth_check
        $error("dtt_debug_regs: DEPTH must be 8");
    end

    logic [7:0]  cmp_a_high_reg;            // comparator a, high byte
    logic [7:0]  cmp_a_low_reg;             // comparator a, low byte
    logic [7:0]  cmp_b_high_reg;            // comparator b, high byte
    logic [7:0]  cmp_b_low_reg;             // comparator b, low byte
    logic [7:0]  control_reg;               // debug_control
    logic [15:0] fifo_reg [DEPTH];          // entry 0 is the head
    logic [3:0]  count_reg;                 // valid words this run
    dtt_pkg::dtt_phase_e phase_reg;         // capture phase
    logic        cpu_wr_ctl;                // cpu writes control
    logic        cpu_wr_cmp;                // cpu write while unarmed
    logic        pop;                       // fifo low read, unarmed
    logic        trigger;                   // trigger event this cycle
    logic        push;                      // capture one word
    logic [15:0] push_word;                 // word captured
    logic        fills;                     // push makes the fifo full
    logic        run_end;                   // run completes this cycle
    logic        arm_bit;                   // shorthand of control arm
    logic        end_trace;                 // end trace in effect

    assign arm_bit    = control_reg[`DTT_CTL_ARM];
    assign end_trace  = !begin_trace_i && !event_only_i;
    assign cpu_wr_ctl = cpu_req_i.wr && cpu_req_i.idx == `DTT_IDX_CONTROL;
    assign cpu_wr_cmp = cpu_req_i.wr && !arm_bit;

    // comparators: address equal and, when qualified, direction equal
    assign match_a_o = bus_i.valid && bus_i.addr == {cmp_a_high_reg, cmp_a_low_reg}
        && (!control_reg[`DTT_CTL_DIR_QUAL_A]
            || bus_i.rd == control_reg[`DTT_CTL_DIR_A]);
    assign match_b_o = bus_i.valid && bus_i.addr == {cmp_b_high_reg, cmp_b_low_reg}
        && (!control_reg[`DTT_CTL_DIR_QUAL_B]
            || bus_i.rd == control_reg[`DTT_CTL_DIR_B]);

    // trigger: a alone, or a or b when b is selected in
    assign trigger = arm_bit && (match_a_o || (trig_use_b_i && match_b_o));

    // capture: event-only stores data bytes on b, otherwise flow addresses
    always_comb begin
        push      = 1'b0;
        push_word = cof_addr_i;
        if (arm_bit && event_only_i) begin
            push      = match_b_o;
            push_word = {8'h00, bus_i.data};
        end else if (arm_bit && end_trace) begin
            push = cof_valid_i;
        end else if (arm_bit) begin
            // begin trace stores only once triggered
            push = cof_valid_i && (phase_reg == dtt_pkg::DTT_FILLING || trigger);
        end
    end

    assign fills   = push && count_reg == 4'(DEPTH - 1);
    // a run completes at fifo full for begin traces, at trigger for end
    assign run_end = (end_trace && trigger) || (!end_trace && fills);
    assign pop     = cpu_req_i.rd && cpu_req_i.idx == `DTT_IDX_FIFO_LOW
        && !arm_bit;

    // comparator bytes: writable only while not armed
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmp_a_high_reg <= `DTT_RST_CMP;
            cmp_a_low_reg  <= `DTT_RST_CMP;
            cmp_b_high_reg <= `DTT_RST_CMP;
            cmp_b_low_reg  <= `DTT_RST_CMP;
        end else if (cpu_wr_cmp) begin
            unique case (cpu_req_i.idx)
                `DTT_IDX_CMP_A_HIGH: cmp_a_high_reg <= cpu_req_i.wdata;
                `DTT_IDX_CMP_A_LOW:  cmp_a_low_reg  <= cpu_req_i.wdata;
                `DTT_IDX_CMP_B_HIGH: cmp_b_high_reg <= cpu_req_i.wdata;
                `DTT_IDX_CMP_B_LOW:  cmp_b_low_reg  <= cpu_req_i.wdata;
                // fifo bytes ignore writes, others are not here
                default: ;
            endcase
        end
    end

    // control register; software write wins over a run ending together
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            control_reg <= `DTT_RST_CONTROL;
        end else if (cpu_wr_ctl) begin
            control_reg <= cpu_req_i.wdata;
            // enable cannot be raised while secured, clearing is free
            control_reg[`DTT_CTL_ENABLE] <= cpu_req_i.wdata[`DTT_CTL_ENABLE]
                && (control_reg[`DTT_CTL_ENABLE] || !secure_i);
            // arm only holds with the module enabled
            control_reg[`DTT_CTL_ARM] <= cpu_req_i.wdata[`DTT_CTL_ARM]
                && cpu_req_i.wdata[`DTT_CTL_ENABLE]
                && (control_reg[`DTT_CTL_ENABLE] || !secure_i);
        end else if (run_end) begin
            control_reg[`DTT_CTL_ARM] <= 1'b0;
        end
    end

    // capture phase: a begin trace waits for its trigger, then fills
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_reg <= dtt_pkg::DTT_IDLE;
        end else if (cpu_wr_ctl || run_end || !arm_bit) begin
            // every run starts over from waiting
            phase_reg <= dtt_pkg::DTT_IDLE;
            if (cpu_wr_ctl && cpu_req_i.wdata[`DTT_CTL_ARM]) begin
                phase_reg <= dtt_pkg::DTT_WAITING;
            end
        end else begin
            unique case (phase_reg)
                dtt_pkg::DTT_IDLE:    phase_reg <= dtt_pkg::DTT_WAITING;
                dtt_pkg::DTT_WAITING: begin
                    if (trigger) begin
                        phase_reg <= dtt_pkg::DTT_FILLING;
                    end
                end
                dtt_pkg::DTT_FILLING: phase_reg <= dtt_pkg::DTT_FILLING;
                default:              phase_reg <= dtt_pkg::DTT_IDLE;
            endcase
        end
    end

    // valid count: cleared at arm, saturates at depth, reads do not touch it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count_reg <= 4'h0;
        end else if (cpu_wr_ctl && cpu_req_i.wdata[`DTT_CTL_ARM]) begin
            count_reg <= 4'h0;
        end else if (push && count_reg != 4'(DEPTH)) begin
            count_reg <= count_reg + 4'h1;
        end
    end

    // fifo as a shift chain: push or pop both move words toward the head,
    // so a circular end trace keeps the newest eight and profiling sees
    // the word it stored eight reads later
    for (genvar i = 0; i < DEPTH; i++) begin : g_fifo
        if (i == DEPTH - 1) begin : g_tail
            // the tail takes the profiling address on a read, else the capture
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    fifo_reg[i] <= 16'h0000;
                end else if (push || pop) begin
                    fifo_reg[i] <= pop ? opcode_addr_i : push_word;
                end
            end
        end else begin : g_body
            // every other word moves one place toward the head
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    fifo_reg[i] <= 16'h0000;
                end else if (push || pop) begin
                    fifo_reg[i] <= fifo_reg[i + 1];
                end
            end
        end
    end

    // registered read data; high byte read has no side effect
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cpu_rdata_o <= `DTT_READ_ZERO;
        end else if (cpu_req_i.rd) begin
            unique case (cpu_req_i.idx)
                `DTT_IDX_CMP_A_HIGH: cpu_rdata_o <= cmp_a_high_reg;
                `DTT_IDX_CMP_A_LOW:  cpu_rdata_o <= cmp_a_low_reg;
                `DTT_IDX_CMP_B_HIGH: cpu_rdata_o <= cmp_b_high_reg;
                `DTT_IDX_CMP_B_LOW:  cpu_rdata_o <= cmp_b_low_reg;
                `DTT_IDX_FIFO_HIGH:  cpu_rdata_o <= event_only_i
                    ? `DTT_READ_ZERO : fifo_reg[0][15:8];
                `DTT_IDX_FIFO_LOW:   cpu_rdata_o <= fifo_reg[0][7:0];
                `DTT_IDX_CONTROL:    cpu_rdata_o <= control_reg;
                // force reset and unmapped indices read zero
                default:             cpu_rdata_o <= `DTT_READ_ZERO;
            endcase
        end
    end

    // force reset: only the background host port reaches it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            force_reset_o <= 1'b0;
        end else begin
            force_reset_o <= host_req_i.wr
                && host_req_i.idx == `DTT_IDX_FORCE_RESET
                && host_req_i.wdata[`DTT_FRC_BIT];
        end
    end

    // break request: end trace at trigger, begin trace when full
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            brk_req_o <= 1'b0;
            brk_tag_o <= 1'b0;
        end else begin
            brk_req_o <= control_reg[`DTT_CTL_BRK_EN]
                && ((end_trace && trigger) || (!end_trace && fills));
            brk_tag_o <= control_reg[`DTT_CTL_TAG];
        end
    end

    assign armed_o = arm_bit;
    assign count_o = count_reg;

    // ---- assertions ----
    frc_reset_host_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        host_req_i.wr && host_req_i.idx == `DTT_IDX_FORCE_RESET
        && host_req_i.wdata[0] |=> force_reset_o)
        else $error("host force reset write did not reset");

    frc_cpu_ignored_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !host_req_i.wr |=> !force_reset_o)
        else $error("force reset without host write");

    cmp_write_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        arm_bit
        |=> $stable({cmp_a_high_reg, cmp_a_low_reg, cmp_b_high_reg, cmp_b_low_reg}))
        else $error("comparator changed while armed");

    fifo_high_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cpu_req_i.rd && cpu_req_i.idx == `DTT_IDX_FIFO_HIGH && event_only_i
        |=> cpu_rdata_o == 8'h00)
        else $error("fifo high nonzero in event-only mode");

    fifo_armed_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        arm_bit && !push |=> fifo_reg[0] == $past(fifo_reg[0]))
        else $error("fifo advanced on armed read");

    fifo_profile_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pop |=> fifo_reg[DEPTH - 1] == $past(opcode_addr_i))
        else $error("profiling read did not store opcode address");

    secure_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        secure_i && !control_reg[7] |=> !control_reg[7])
        else $error("enable set while secured");

    run_end_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        run_end && !cpu_wr_ctl |=> !arm_bit)
        else $error("arm not cleared at run end");

    count_no_dec_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(cpu_wr_ctl && cpu_req_i.wdata[6]) |=> count_reg >= $past(count_reg))
        else $error("valid count decremented");

    break_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        control_reg[`DTT_CTL_BRK_EN] && end_trace && trigger
        |=> brk_req_o && brk_tag_o == $past(control_reg[`DTT_CTL_TAG]))
        else $error("end trace break missing");

    match_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        match_a_o && control_reg[2] |-> bus_i.rd == control_reg[3])
        else $error("comparator a ignored direction");

    // comparator b honours its direction qualifier
    match_dir_b_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        match_b_o && control_reg[`DTT_CTL_DIR_QUAL_B]
        |-> bus_i.rd == control_reg[`DTT_CTL_DIR_B])
        else $error("comparator b ignored direction");

    // a high byte read leaves the head word where it is
    fifo_high_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cpu_req_i.rd && cpu_req_i.idx == `DTT_IDX_FIFO_HIGH && !push
        |=> fifo_reg[0] == $past(fifo_reg[0]))
        else $error("fifo advanced on high byte read");

    // an unarmed low byte read brings the next word to the head
    fifo_pop_shift_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pop |=> fifo_reg[0] == $past(fifo_reg[1]))
        else $error("fifo did not advance on low byte read");

    // a begin trace breaks when its last word lands
    break_begin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        control_reg[`DTT_CTL_BRK_EN] && !end_trace && fills |=> brk_req_o)
        else $error("begin trace break missing");

    // arming starts the count over
    count_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cpu_wr_ctl && cpu_req_i.wdata[`DTT_CTL_ARM] |=> count_reg == 4'h0)
        else $error("valid count not cleared at arm");

    // the count never passes the fifo depth
    count_ceiling_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        count_reg <= 4'(DEPTH))
        else $error("valid count above depth");

    // the low control bits follow every write, armed or not
    ctl_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cpu_wr_ctl |=> control_reg[5:0] == $past(cpu_req_i.wdata[5:0]))
        else $error("control write not taken");

    // a run can only be armed inside an enabled module
    arm_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        arm_bit |-> control_reg[`DTT_CTL_ENABLE])
        else $error("armed without enable");

endmodule // dtt_debug_regs

// ### dtt_host_model.sv
// behavioural background debug host on the host write port of the block
// assumes the bench calls its task just after a rising clock edge
module dtt_host_model (
    // clock
    input  wire logic            clk_i,
    // host write requests
    output dtt_pkg::dtt_reg_req_s host_req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle port at time zero: no stray write can reach the block
    initial begin
        host_req_o = '0;
    end

    // one serial byte-write command: held for one edge, then released
    task automatic write_byte(input logic [3:0] idx, input logic [7:0] d);
        host_req_o <= '{rd: 1'b0, wr: 1'b1, idx: idx, wdata: d};
        @(posedge clk_i);
        // an extra edge keeps two writes from landing in one step
        host_req_o <= '0;
        @(posedge clk_i);
    endtask
endmodule // dtt_host_model

// ### dtt_pkg.sv
// types shared by the debug trace/trigger register block
// assumes the constants come from dtt_regs.svh
package dtt_pkg;

    // one cpu bus cycle as seen by the comparators
    typedef struct packed {
        logic        valid;  // a bus cycle occurs this clock
        logic        rd;     // 1 read, 0 write
        logic [15:0] addr;   // cpu address
        logic [7:0]  data;   // data byte of the cycle
    } dtt_bus_s;

    // one register access request
    typedef struct packed {
        logic       rd;      // read strobe, one cycle
        logic       wr;      // write strobe, one cycle
        logic [3:0] idx;     // register index
        logic [7:0] wdata;   // write data
    } dtt_reg_req_s;

    // run phase of the capture logic
    typedef enum logic [1:0] {
        DTT_IDLE    = 2'b00,
        DTT_WAITING = 2'b01,
        DTT_FILLING = 2'b10
    } dtt_phase_e;

endpackage

// ### dtt_regs.svh
// register indices, control field positions and reset values of the
// debug trace/trigger register block; definitions only
`ifndef DTT_REGS_SVH
`define DTT_REGS_SVH

// register indices on the cpu register port
`define DTT_IDX_CMP_A_HIGH   4'h0
`define DTT_IDX_CMP_A_LOW    4'h1
`define DTT_IDX_CMP_B_HIGH   4'h2
`define DTT_IDX_CMP_B_LOW    4'h3
`define DTT_IDX_FIFO_HIGH    4'h4
`define DTT_IDX_FIFO_LOW     4'h5
`define DTT_IDX_CONTROL      4'h6
// host-only force reset register index on the background port
`define DTT_IDX_FORCE_RESET  4'h9

// debug_control field positions
`define DTT_CTL_ENABLE       7
`define DTT_CTL_ARM          6
`define DTT_CTL_TAG          5
`define DTT_CTL_BRK_EN       4
`define DTT_CTL_DIR_A        3
`define DTT_CTL_DIR_QUAL_A   2
`define DTT_CTL_DIR_B        1
`define DTT_CTL_DIR_QUAL_B   0
// force_reset_bit position
`define DTT_FRC_BIT          0

// reset values
`define DTT_RST_CMP          8'h00
`define DTT_RST_CONTROL      8'h00
`define DTT_READ_ZERO        8'h00

`endif

// ### tb_top.sv
// self-checking bench of the debug register block
// assumes the host model file and the design package compile first
`include "dtt_regs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("FAIL %0t: got %h exp %h", $time, got, exp); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk_i;        // bus clock
    logic                  rst_n_i;      // sync reset, active low
    dtt_pkg::dtt_reg_req_s cpu_req;      // cpu register request
    dtt_pkg::dtt_reg_req_s host_req;     // host model request
    dtt_pkg::dtt_bus_s     bus;          // observed bus cycle
    logic [7:0]            rdata;        // cpu read data
    logic [15:0]           op_addr;      // last opcode address
    logic                  cof_v;        // change-of-flow strobe
    logic [15:0]           cof_a;        // change-of-flow address
    logic                  secure, beg, evo, use_b;
    logic                  frc, armed, ma, mb, brk, tag, tag_at_brk;
    logic [3:0]            cnt;          // valid word count
    logic [7:0]            d;            // scratch read value
    int                    miscompares, checks_done, brk_n, frc_n, cyc_n;
    logic [7:0]            cv[4] = '{8'h12, 8'h34, 8'h56, 8'h78};

    dtt_debug_regs u_dtt_debug_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_req_i(cpu_req),
        .cpu_rdata_o(rdata), .host_req_i(host_req), .force_reset_o(frc), .secure_i(secure),
        .bus_i(bus), .cof_valid_i(cof_v), .cof_addr_i(cof_a), .opcode_addr_i(op_addr),
        .begin_trace_i(beg), .event_only_i(evo), .trig_use_b_i(use_b), .armed_o(armed),
        .count_o(cnt), .match_a_o(ma), .match_b_o(mb), .brk_req_o(brk), .brk_tag_o(tag));
    dtt_host_model u_dtt_host_model (.clk_i(clk_i), .host_req_o(host_req));

    // 40 ns bus clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // pulse counters and a hang guard; runs take well under 3000 cycles
    always @(posedge clk_i) begin
        brk_n += int'(brk === 1'b1);
        frc_n += int'(frc === 1'b1);
        if (brk === 1'b1) tag_at_brk = tag;
        cyc_n++;
        if (cyc_n == 3000) begin
            miscompares++;
            end_sim();
        end
    end

    // verdict and end of run
    task automatic end_sim();
        if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // cpu write: request held for one edge, then a quiet edge
    task automatic wr(input logic [3:0] i, input logic [7:0] v);
        cpu_req <= '{rd: 1'b0, wr: 1'b1, idx: i, wdata: v};
        @(posedge clk_i);
        cpu_req <= '0;
        @(posedge clk_i);
    endtask

    // cpu read: data registered at the taking edge, sampled one edge later
    task automatic rd(input logic [3:0] i, output logic [7:0] v);
        cpu_req <= '{rd: 1'b1, wr: 1'b0, idx: i, wdata: 8'h00};
        @(posedge clk_i);
        cpu_req <= '0;
        @(posedge clk_i);
        v = rdata;
    endtask

    // one bus cycle; comparator outputs checked while it is on the bus
    task automatic cyc(input logic r, input logic [15:0] a, input logic [7:0] v,
                       input logic ea, input logic eb);
        bus <= '{valid: 1'b1, rd: r, addr: a, data: v};
        @(posedge clk_i);
        `CHK(ma, ea)
        `CHK(mb, eb)
        bus <= '0;
        @(posedge clk_i);
    endtask

    // one change-of-flow strobe held for one edge, then a quiet edge
    task automatic cof(input logic [15:0] a);
        cof_a <= a;
        cof_v <= 1'b1;
        @(posedge clk_i);
        cof_v <= 1'b0;
        @(posedge clk_i);
    endtask

    initial begin
        rst_n_i = 1'b0;  cpu_req = '0;  bus = '0;  op_addr = 16'h0000;
        secure = 1'b0;  beg = 1'b0;  evo = 1'b0;  use_b = 1'b0;
        cof_v = 1'b0;
        cof_a = 16'h0000;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        // reset values, and cpu cannot reach the force reset register
        for (int i = 0; i < 4; i++) begin
            rd(4'(i), d);
            `CHK(d, 8'h00)
        end
        rd(`DTT_IDX_CONTROL, d);
        `CHK(d, 8'h00)
        wr(`DTT_IDX_FORCE_RESET, 8'h01);
        rd(`DTT_IDX_FORCE_RESET, d);
        `CHK(d, 8'h00)
        `CHK(frc_n, 0)
        // host writes: bit0 clear does nothing, bit0 set gives one pulse
        u_dtt_host_model.write_byte(`DTT_IDX_FORCE_RESET, 8'hfe);
        u_dtt_host_model.write_byte(`DTT_IDX_FORCE_RESET, 8'h01);
        repeat (3) @(posedge clk_i);
        `CHK(frc_n, 1)
        // comparator bytes write and read back while unarmed
        for (int i = 0; i < 4; i++) wr(4'(i), cv[i]);
        for (int i = 0; i < 4; i++) begin
            rd(4'(i), d);
            `CHK(d, cv[i])
        end
        // secured part refuses the enable bit
        secure <= 1'b1;
        wr(`DTT_IDX_CONTROL, 8'hc0);
        rd(`DTT_IDX_CONTROL, d);
        `CHK(d, 8'h00)
        secure <= 1'b0;
        // direction qualification of both comparators
        wr(`DTT_IDX_CONTROL, 8'h8c);
        cyc(1'b0, 16'h1234, 8'h00, 1'b0, 1'b0);
        cyc(1'b1, 16'h1234, 8'h00, 1'b1, 1'b0);
        cyc(1'b1, 16'h5678, 8'h00, 1'b0, 1'b1);
        wr(`DTT_IDX_CONTROL, 8'h89);
        cyc(1'b0, 16'h1234, 8'h00, 1'b1, 1'b0);
        cyc(1'b1, 16'h5678, 8'h00, 1'b0, 1'b0);
        cyc(1'b0, 16'h5678, 8'h00, 1'b0, 1'b1);
        // profiling: eight priming reads, then the first stored address returns
        for (int k = 0; k < 8; k++) begin
            op_addr <= {8'ha0 + 8'(k), 8'h50 + 8'(k)};
            rd(`DTT_IDX_FIFO_LOW, d);
        end
        rd(`DTT_IDX_FIFO_HIGH, d);
        `CHK(d, 8'ha0)
        rd(`DTT_IDX_FIFO_HIGH, d);
        `CHK(d, 8'ha0)
        rd(`DTT_IDX_FIFO_LOW, d);
        `CHK(d, 8'h50)
        rd(`DTT_IDX_FIFO_HIGH, d);
        `CHK(d, 8'ha1)
        // end trace run: comparator locked, trigger ends run with force break
        wr(`DTT_IDX_CONTROL, 8'hd0);
        `CHK(armed, 1'b1)
        wr(`DTT_IDX_CMP_A_HIGH, 8'hff);
        rd(`DTT_IDX_CMP_A_HIGH, d);
        `CHK(d, 8'h12)
        rd(`DTT_IDX_CONTROL, d);
        `CHK(d, 8'hd0)
        cyc(1'b0, 16'h1234, 8'h00, 1'b1, 1'b0);
        repeat (3) @(posedge clk_i);
        `CHK(armed, 1'b0)
        `CHK(brk_n, 1)
        `CHK(tag_at_brk, 1'b0)
        // same run with tag type breaks
        wr(`DTT_IDX_CONTROL, 8'hf0);
        cyc(1'b0, 16'h1234, 8'h00, 1'b1, 1'b0);
        repeat (3) @(posedge clk_i);
        `CHK(brk_n, 2)
        `CHK(tag_at_brk, 1'b1)
        // begin trace: nothing stored before the trigger, run ends when full
        beg <= 1'b1;
        wr(`DTT_IDX_CONTROL, 8'hd0);
        cof(16'hbeef);
        cyc(1'b0, 16'h1234, 8'h00, 1'b1, 1'b0);
        for (int k = 0; k < 8; k++) cof({8'hc0 + 8'(k), 8'h10 + 8'(k)});
        repeat (3) @(posedge clk_i);
        `CHK(armed, 1'b0)
        `CHK(cnt, 4'h8)
        `CHK(brk_n, 3)
        for (int k = 0; k < 8; k++) begin
            rd(`DTT_IDX_FIFO_HIGH, d);
            `CHK(d, 8'hc0 + 8'(k))
            rd(`DTT_IDX_FIFO_LOW, d);
            `CHK(d, 8'h10 + 8'(k))
        end
        // event-only run stores data bytes; an armed read must not advance
        beg <= 1'b1;  evo <= 1'b1;  use_b <= 1'b1;
        wr(`DTT_IDX_CONTROL, 8'hd0);
        `CHK(cnt, 4'h0)
        for (int k = 0; k < 8; k++) begin
            cyc(1'b0, 16'h5678, 8'h30 + 8'(k), 1'b0, 1'b1);
            if (k == 2) rd(`DTT_IDX_FIFO_LOW, d);
        end
        repeat (3) @(posedge clk_i);
        `CHK(cnt, 4'h8)
        `CHK(armed, 1'b0)
        `CHK(brk_n, 4)
        wr(`DTT_IDX_FIFO_LOW, 8'hff);
        wr(`DTT_IDX_FIFO_HIGH, 8'hff);
        rd(`DTT_IDX_FIFO_HIGH, d);
        `CHK(d, 8'h00)
        for (int k = 0; k < 8; k++) begin
            rd(`DTT_IDX_FIFO_LOW, d);
            `CHK(d, 8'h30 + 8'(k))
        end
        `CHK(cnt, 4'h8)
        // a run is stopped by hand when arm is written zero
        wr(`DTT_IDX_CONTROL, 8'hd0);
        `CHK(armed, 1'b1)
        wr(`DTT_IDX_CONTROL, 8'h80);
        `CHK(armed, 1'b0)
        end_sim();
    end
endmodule // tb_top
